// *** rtl/quadrature_filter_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none

module quadrature_filter_decoder (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PHASE_A_INPUT_IN,
  input wire logic PHASE_B_INPUT_IN,
  output logic PHASE_A_FILTERED_OUT,
  output logic PHASE_B_FILTERED_OUT,
  output logic COUNT_STROBE_OUT,
  output logic COUNT_UP_OUT,
  output logic DECODE_COUNT_PULSE_OUT,
  output logic DECODE_UP_OUT
);

  // ---------------------------------------------------------------------------
  // Start-up and filters
  // ---------------------------------------------------------------------------
  logic init_reg;
  logic phase_a_filtered;
  logic phase_b_filtered;

  // One cycle after reset release the filters and state take the live inputs.
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      init_reg <= 1'h1;
    end else begin
      init_reg <= 1'h0;
    end
  end

  phase_filter u_filter_a (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .init_in(init_reg),
    .raw_in(PHASE_A_INPUT_IN),
    .filt_out(phase_a_filtered)
  );

  phase_filter u_filter_b (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .init_in(init_reg),
    .raw_in(PHASE_B_INPUT_IN),
    .filt_out(phase_b_filtered)
  );

  // ---------------------------------------------------------------------------
  // 4X decoder
  // ---------------------------------------------------------------------------
  logic [1:0] prev_state_reg;
  logic [1:0] pres_state;
  logic step_up;
  logic step_down;
  logic strobe_reg;
  logic up_reg;
  logic pulse_reg;
  logic dec_up_reg;
  logic fa_reg;
  logic fb_reg;

  // Next state along the up Gray sequence.
  function automatic logic [1:0] up_succ(input logic [1:0] s);
    unique case (s)
      qfd_pkg::QSTATE_0: up_succ = qfd_pkg::QSTATE_1;
      qfd_pkg::QSTATE_1: up_succ = qfd_pkg::QSTATE_2;
      qfd_pkg::QSTATE_2: up_succ = qfd_pkg::QSTATE_3;
      qfd_pkg::QSTATE_3: up_succ = qfd_pkg::QSTATE_0;
    endcase
  endfunction : up_succ

  assign pres_state = {phase_a_filtered, phase_b_filtered};
  assign step_up = (pres_state == up_succ(prev_state_reg));
  assign step_down = (prev_state_reg == up_succ(pres_state));

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      prev_state_reg <= qfd_pkg::QSTATE_0;
    end else if (init_reg) begin
      prev_state_reg <= {PHASE_A_INPUT_IN, PHASE_B_INPUT_IN};
    end else begin
      prev_state_reg <= pres_state;
    end
  end

  // A double change has neither neighbour relation and counts nothing; that is
  // the arbitrary outcome allowed for illegal jumps.
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      strobe_reg <= 1'h0;
    end else begin
      strobe_reg <= !init_reg && (step_up || step_down);
    end
  end

  // Direction holds its last value between counts.
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      up_reg <= qfd_pkg::DIR_UP;
    end else if (!init_reg && step_up) begin
      up_reg <= qfd_pkg::DIR_UP;
    end else if (!init_reg && step_down) begin
      up_reg <= qfd_pkg::DIR_DOWN;
    end
  end

  // ---------------------------------------------------------------------------
  // External pins
  // ---------------------------------------------------------------------------
  // The pin pulse is one full cycle wide, one cycle after the internal strobe.
  // A half-cycle pulse would need the falling edge, which this clocking forbids.
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pulse_reg <= 1'h0;
    end else begin
      pulse_reg <= strobe_reg;
    end
  end

  // The direction pin moves at the strobe edge, so it is settled a cycle before
  // the pin pulse rises. The filter keeps reversals at least three cycles apart,
  // which holds it a cycle after that rise as well.
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dec_up_reg <= qfd_pkg::DIR_UP;
    end else if (!init_reg && step_up) begin
      dec_up_reg <= qfd_pkg::DIR_UP;
    end else if (!init_reg && step_down) begin
      dec_up_reg <= qfd_pkg::DIR_DOWN;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      fa_reg <= 1'h0;
      fb_reg <= 1'h0;
    end else begin
      fa_reg <= phase_a_filtered;
      fb_reg <= phase_b_filtered;
    end
  end

  assign PHASE_A_FILTERED_OUT = fa_reg;
  assign PHASE_B_FILTERED_OUT = fb_reg;
  assign COUNT_STROBE_OUT = strobe_reg;
  assign COUNT_UP_OUT = up_reg;
  assign DECODE_COUNT_PULSE_OUT = pulse_reg;
  assign DECODE_UP_OUT = dec_up_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Most decode checks skip the start-up cycle, in which both state copies take the pins.
  a_count_on_step: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (!init_reg && pres_state != prev_state_reg && (pres_state ^ prev_state_reg) != 2'h3)
      |=> strobe_reg)
    else $error("adjacent transition gave no count");
  a_no_idle_count: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (pres_state == prev_state_reg) |=> !strobe_reg)
    else $error("count without state change");
  a_jump_quiet: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (!init_reg && (pres_state ^ prev_state_reg) == 2'h3) |=> !strobe_reg)
    else $error("double change produced a count");
  a_dir_up: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (!init_reg && prev_state_reg == 2'h0 && pres_state == 2'h2) |=> up_reg && strobe_reg)
    else $error("A leading B not counted up");
  a_dir_down: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (!init_reg && prev_state_reg == 2'h0 && pres_state == 2'h1) |=> !up_reg && strobe_reg)
    else $error("B leading A not counted down");
  a_up_wrap: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (!init_reg && prev_state_reg == qfd_pkg::QSTATE_3 && pres_state == qfd_pkg::QSTATE_0)
      |=> up_reg && strobe_reg)
    else $error("wrap to the first state not counted up");
  a_latency_max: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RESET_N_IN || init_reg)
    (PHASE_A_INPUT_IN [*3]) ##1 !$past(phase_a_filtered,3) |-> ##[0:4] phase_a_filtered)
    else $error("accepted change too slow");
  a_pin_follows: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    1'b1 |=> DECODE_COUNT_PULSE_OUT == $past(strobe_reg))
    else $error("pin pulse does not follow the count strobe");
  a_dir_setup: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    $rose(DECODE_COUNT_PULSE_OUT) |-> $stable(DECODE_UP_OUT))
    else $error("direction not settled before count");
  a_dir_hold: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    $rose(DECODE_COUNT_PULSE_OUT) |=> $stable(DECODE_UP_OUT))
    else $error("direction moved after count");
  a_init_quiet: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    init_reg |=> !strobe_reg ##1 !strobe_reg)
    else $error("spurious count after start-up");

  // Covers for both directions, a reversal, the pin pulse and a double jump.
  c_double_jump: cover property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !init_reg && (pres_state ^ prev_state_reg) == 2'h3);
  c_count_up: cover property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    strobe_reg && up_reg);
  c_count_down: cover property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    strobe_reg && !up_reg);
  c_reversal: cover property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (strobe_reg && up_reg) ##[1:40] (strobe_reg && !up_reg));
  c_pin_pulse: cover property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    $rose(DECODE_COUNT_PULSE_OUT));

endmodule : quadrature_filter_decoder

`default_nettype wire

// *** rtl/qfd_pkg.sv ***
package qfd_pkg;

  // ---------------------------------------------------------------------------
  // Filter and decoder constants
  // ---------------------------------------------------------------------------
  localparam int unsigned HIST_BITS = 4;
  localparam int unsigned STABLE_EDGES = 3;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MAX_PROP_CLKS = 7;
  localparam int unsigned MIN_REJECT_CLKS = 2;
  localparam logic [1:0] QSTATE_0 = 2'h0;
  localparam logic [1:0] QSTATE_1 = 2'h2;
  localparam logic [1:0] QSTATE_2 = 2'h3;
  localparam logic [1:0] QSTATE_3 = 2'h1;
  localparam logic DIR_UP = 1'h1;
  localparam logic DIR_DOWN = 1'h0;

endpackage : qfd_pkg

// *** rtl/phase_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module phase_filter (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic init_in,
  input wire logic raw_in,
  output logic filt_out
);

  logic [qfd_pkg::HIST_BITS-1:0] hist_reg;
  logic filt_reg;
  logic all_high;
  logic all_low;

  // The newest three samples must agree before the output follows them.
  assign all_high = &hist_reg[qfd_pkg::STABLE_EDGES-1:0];
  assign all_low = ~|hist_reg[qfd_pkg::STABLE_EDGES-1:0];

  // Reset loads zero; the first cycle after release reloads from the input.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hist_reg <= '0;
    end else if (init_in) begin
      hist_reg <= {qfd_pkg::HIST_BITS{raw_in}};
    end else begin
      hist_reg <= {hist_reg[qfd_pkg::HIST_BITS-2:0], raw_in};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      filt_reg <= 1'h0;
    end else if (init_in) begin
      filt_reg <= raw_in;
    end else if (all_high) begin
      filt_reg <= 1'h1;
    end else if (all_low) begin
      filt_reg <= 1'h0;
    end
  end

  assign filt_out = filt_reg;

  a_filter_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!init_in && !$past(init_in) && $changed(filt_reg)) |->
      (hist_reg[1] == filt_reg && hist_reg[2] == filt_reg && hist_reg[3] == filt_reg))
    else $error("filtered level changed without three equal samples");

  a_short_reject: assert property (@(posedge clk_in) disable iff (!rst_n_in || init_in)
    ((!raw_in) [*3] ##1 raw_in ##1 !raw_in) |=> (!filt_reg) [*3])
    else $error("one-cycle pulse passed the filter");

endmodule : phase_filter

`default_nettype wire

// *** verif/encoder_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module encoder_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic step_in,
  input wire logic up_in,
  input wire logic jump_in,
  input wire logic glitch_in,
  output logic phase_a_out,
  output logic phase_b_out
);
  logic [1:0] qstate_reg;

  // Moves only on request, so each level and state is held as long as the bench waits.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      qstate_reg <= 2'h0;
    end else if (jump_in) begin
      qstate_reg <= ~qstate_reg;
    end else if (step_in) begin
      qstate_reg <= up_in ? {~qstate_reg[0], qstate_reg[1]} : {qstate_reg[0], ~qstate_reg[1]};
    end
  end

  // A glitch inverts phase A for whole cycles only, to probe the noise filter.
  assign phase_a_out = qstate_reg[1] ^ glitch_in;
  assign phase_b_out = qstate_reg[0];
endmodule : encoder_model

`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk, rst_n, dut_rst_n, step, up, jump, glitch;
  logic fa, fb, cs, cu, dp, du, pa, pb;
  int n_errors = 0;
  int comparisons = 0;

  encoder_model encoder_model_i (.clk_in(clk), .rst_n_in(rst_n), .step_in(step), .up_in(up),
    .jump_in(jump), .glitch_in(glitch), .phase_a_out(pa), .phase_b_out(pb));

  quadrature_filter_decoder quadrature_filter_decoder_i (.SYS_CLK_IN(clk), .RESET_N_IN(dut_rst_n),
    .PHASE_A_INPUT_IN(pa), .PHASE_B_INPUT_IN(pb), .PHASE_A_FILTERED_OUT(fa),
    .PHASE_B_FILTERED_OUT(fb), .COUNT_STROBE_OUT(cs), .COUNT_UP_OUT(cu),
    .DECODE_COUNT_PULSE_OUT(dp), .DECODE_UP_OUT(du));

  initial begin
    clk = 1'b0;
    forever #(qfd_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task automatic check(input string what, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // One encoder move, then ten cycles of watching strobes and the pin pulse.
  task automatic move(input logic dir, input logic dbl, input int exp_n);
    int n;
    int lat;
    logic prev;
    n = 0;
    lat = 0;
    prev = 1'b0;
    @(posedge clk);
    step <= 1'b1;
    up <= dir;
    jump <= dbl;
    @(posedge clk);
    step <= 1'b0;
    jump <= 1'b0;
    for (int i = 1; i <= 10; i++) begin
      @(posedge clk);
      #1;
      if (prev === 1'b1) begin
        check("pin pulse", dp, 1'b1);
        check("pin dir", du, dir);
      end else begin
        check("pin idle", dp, 1'b0);
      end
      if (cs === 1'b1) begin
        n++;
        lat = i;
        check("dir", cu, dir);
        check("pin dir setup", du, dir);
      end
      prev = cs;
    end
    check("count n", n == exp_n, 1'b1);
    check("latency", lat <= qfd_pkg::MAX_PROP_CLKS, 1'b1);
    check("filt a", fa, pa);
    check("filt b", fb, pb);
  endtask : move

  task automatic t_startup();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      check("idle strobe", cs, 1'b0);
      check("idle dir", cu, 1'b1);
    end
    $display("test startup done");
  endtask : t_startup

  task automatic t_cycles();
    repeat (4) move(1'b1, 1'b0, 1);
    check("up wrap", {pa, pb} == 2'h0, 1'b1);
    repeat (4) move(1'b0, 1'b0, 1);
    move(1'b1, 1'b0, 1);
    move(1'b0, 1'b0, 1);
    $display("test cycles done");
  endtask : t_cycles

  // Pulses of one and two samples must vanish; three samples pass and count twice.
  task automatic t_glitch();
    int n;
    for (int w = 1; w <= 3; w++) begin
      n = 0;
      @(posedge clk);
      glitch <= 1'b1;
      repeat (w) @(posedge clk);
      glitch <= 1'b0;
      repeat (12) begin
        @(posedge clk);
        #1;
        if (cs === 1'b1) n++;
      end
      check("glitch n", n == ((w == 3) ? 2 : 0), 1'b1);
    end
    $display("test glitch done");
  endtask : t_glitch

  task automatic t_jump();
    move(1'b1, 1'b1, 0);
    move(1'b1, 1'b0, 1);
    $display("test jump done");
  endtask : t_jump

  // The decoder alone restarts while the encoder rests away from the reset state.
  task automatic t_restart();
    @(posedge clk);
    dut_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    dut_rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      check("restart strobe", cs, 1'b0);
      check("restart dir", cu, qfd_pkg::DIR_UP);
    end
    check("restart filt a", fa, pa);
    check("restart filt b", fb, pb);
    move(1'b0, 1'b0, 1);
    $display("test restart done");
  endtask : t_restart

  initial begin
    rst_n = 1'b0;
    dut_rst_n = 1'b0;
    step = 1'b0;
    up = 1'b0;
    jump = 1'b0;
    glitch = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    dut_rst_n <= 1'b1;
    t_startup();
    t_cycles();
    t_glitch();
    t_jump();
    t_restart();
    final_report();
  end

  // The scenarios take a few hundred cycles; this limit only cuts a hang short.
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
